// ==== src/ram_backup_power_control.sv ====
// ram_backup_power_control: back-up state entry/exit, warm/cold start flag, reset merging
// assumes: cpu core presents one executed instruction per valid cycle and restarts at
// address 0 page 0 when cpu_restart pulses; pins arrive asynchronously
`timescale 1ns/1ns
module ram_backup_power_control
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // cpu core
    input wire backup_pkg::cpu_instr_type instr,
    output logic skip_next,
    output logic cpu_restart,
    output logic cpu_hold,
    output logic backup_flag,
    // reset and wakeup sources
    input wire logic reset_n_pin,
    input wire logic watchdog_reset,
    input wire logic voltage_low,
    input wire logic voltage_detect_enable_pin,
    input wire logic wakeup_pin,
    // clock and core controls
    output logic osc_stop,
    output logic onchip_osc_select,
    output logic ext_osc_run,
    output logic ram_write_block,
    output logic carry_flag_clear,
    output logic interrupt_enable_flag,
    output logic volatile_clear,
    // register bus
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    localparam logic [4:0] SYNC_RST = 5'b1_0_0_0_0;

    logic [4:0] pins_sync;
    backup_pkg::reset_sources_type src;

    input_sync #(
        .WIDTH(5),
        .RESET_VALUE(SYNC_RST)
    ) pin_sync_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in({reset_n_pin, watchdog_reset, voltage_low, voltage_detect_enable_pin,
            wakeup_pin}),
        .sync_out(pins_sync)
    );

    assign src = pins_sync;

    // ------------------------------------------------------------
    // state and instruction tracking
    // ------------------------------------------------------------
    backup_pkg::power_state_type state;
    backup_pkg::power_state_type next_state;
    logic power_off_go;
    logic armed;
    logic cold_event;
    logic vdrop_hit;
    logic pin_low_seen;
    logic sw_reset_hit;
    logic ctrl_sw_reset;
    logic sw_request;
    logic [3:0] int_status;
    logic [3:0] int_mask;
    logic [3:0] events;
    backup_pkg::retained_ctrl_type retained;
    logic [3:0] ctrl_bits;

    arm_tracker arm_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .instr(instr),
        .flush(cold_event || state != backup_pkg::ST_RUN),
        .power_off_go(power_off_go),
        .armed(armed)
    );

    function automatic logic is_op(input backup_pkg::cpu_instr_type i,
        input backup_pkg::cpu_op_type o);
        is_op = i.valid && i.op == o;
    endfunction

    // detector gated by its enable pin
    assign vdrop_hit = src.vdrop && src.vdrop_enable;

    assign sw_reset_hit = is_op(instr, backup_pkg::OP_SW_RESET) && state == backup_pkg::ST_RUN;

    // restart fires when the pin rises after being held low
    assign cold_event = (pin_low_seen && src.pin_reset_n) || !src.pin_reset_n
        || src.watchdog || vdrop_hit || sw_reset_hit || sw_request;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pin_low_seen <= 1'b0;
        end
        else if (clk_en)
        begin
            pin_low_seen <= !src.pin_reset_n;
        end
    end

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            backup_pkg::ST_RUN:
            begin
                if (power_off_go)
                begin
                    next_state = backup_pkg::ST_BACKUP;
                end
            end
            backup_pkg::ST_BACKUP:
            begin
                if (src.wakeup)
                begin
                    next_state = backup_pkg::ST_RESTART;
                end
            end
            backup_pkg::ST_RESTART:
            begin
                next_state = backup_pkg::ST_RUN;
            end
            default:
            begin
                next_state = backup_pkg::ST_RUN;
            end
        endcase
        // drop or any cold source forces restart, or run while the reset pin is low
        if (cold_event)
        begin
            next_state = src.pin_reset_n ? backup_pkg::ST_RESTART : backup_pkg::ST_RUN;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= backup_pkg::ST_RUN;
        end
        else if (clk_en)
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // back-up flag
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            backup_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cold_event)
            begin
                backup_flag <= 1'b0;
            end
            // set on entry, held through wakeup
            else if (power_off_go)
            begin
                backup_flag <= 1'b1;
            end
        end
    end

    assign skip_next = is_op(instr, backup_pkg::OP_SKIP_BACKUP) && backup_flag
        && state == backup_pkg::ST_RUN;

    // unarmed power-off falls through as a plain instruction
    assign cpu_hold = state == backup_pkg::ST_BACKUP || !src.pin_reset_n;

    // ------------------------------------------------------------
    // restart and core side controls
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cpu_restart <= 1'b1;
            volatile_clear <= 1'b1;
        end
        else if (clk_en)
        begin
            // restart from page 0 address 0 on wakeup or cold start
            cpu_restart <= next_state == backup_pkg::ST_RESTART;
            // volatile state dropped after back-up or reset
            volatile_clear <= next_state == backup_pkg::ST_RESTART;
        end
    end

    // oscillator stops and ram writes blocked in back-up
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            osc_stop <= 1'b0;
            ram_write_block <= 1'b0;
        end
        else if (clk_en)
        begin
            osc_stop <= next_state == backup_pkg::ST_BACKUP;
            ram_write_block <= next_state == backup_pkg::ST_BACKUP;
        end
    end

    // on-chip oscillator after reset, others stopped, carry cleared
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            onchip_osc_select <= 1'b1;
            ext_osc_run <= 1'b0;
            carry_flag_clear <= 1'b1;
        end
        else if (clk_en)
        begin
            carry_flag_clear <= cold_event;
            if (cold_event)
            begin
                onchip_osc_select <= 1'b1;
                ext_osc_run <= 1'b0;
            end
            else if (reg_write && reg_addr == backup_pkg::OFS_CTRL)
            begin
                onchip_osc_select <= !reg_wdata[2];
                ext_osc_run <= reg_wdata[2];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            interrupt_enable_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cold_event || next_state == backup_pkg::ST_RESTART)
            begin
                interrupt_enable_flag <= 1'b0;
            end
            else if (reg_write && reg_addr == backup_pkg::OFS_CTRL)
            begin
                interrupt_enable_flag <= reg_wdata[0];
            end
        end
    end

    // software-requested reset through control bit 1
    assign ctrl_sw_reset = reg_write && reg_addr == backup_pkg::OFS_CTRL && reg_wdata[1];

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sw_request <= 1'b0;
        end
        else if (clk_en)
        begin
            sw_request <= ctrl_sw_reset;
        end
    end

    // retained controls change only on pin reset or software write
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            retained <= backup_pkg::RETAIN_RST;
        end
        else if (clk_en)
        begin
            if (!src.pin_reset_n)
            begin
                retained <= backup_pkg::RETAIN_RST;
            end
            else if (reg_write && reg_addr == backup_pkg::OFS_RETAIN)
            begin
                retained <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    assign events = {vdrop_hit, power_off_go, cold_event, src.wakeup
        && state == backup_pkg::ST_BACKUP};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            int_status <= 4'h0;
        end
        else if (clk_en)
        begin
            // set wins over write-one-to-clear
            if (reg_write && reg_addr == backup_pkg::OFS_INT_STATUS)
            begin
                int_status <= (int_status & ~reg_wdata[3:0]) | events;
            end
            else
            begin
                int_status <= int_status | events;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            int_mask <= backup_pkg::INT_MASK_RST;
        end
        else if (clk_en && reg_write && reg_addr == backup_pkg::OFS_INT_MASK)
        begin
            int_mask <= reg_wdata[3:0];
        end
    end

    assign irq = |(int_status & int_mask);

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    assign ctrl_bits = {1'b0, ext_osc_run, 1'b0, interrupt_enable_flag};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata <= 8'h00;
        end
        else if (clk_en)
        begin
            reg_rdata <= 8'h00;
            if (reg_read)
            begin
                case (reg_addr)
                    backup_pkg::OFS_CTRL: reg_rdata <= {4'h0, ctrl_bits};
                    backup_pkg::OFS_STATUS: reg_rdata <= {3'h0, armed, backup_flag,
                        src.vdrop_enable, state};
                    backup_pkg::OFS_INT_STATUS: reg_rdata <= {4'h0, int_status};
                    backup_pkg::OFS_INT_MASK: reg_rdata <= {4'h0, int_mask};
                    backup_pkg::OFS_RETAIN: reg_rdata <= retained;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule

// ==== inc/backup_pkg.sv ====
// package: shared types and constants for the ram back-up power controller
// assumes: single 10 MHz clock domain, synchronous active-high reset
package backup_pkg;

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h1;
    localparam logic [3:0] OFS_INT_STATUS = 4'h2;
    localparam logic [3:0] OFS_INT_MASK = 4'h3;
    localparam logic [3:0] OFS_RETAIN = 4'h4;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int EV_WAKE = 0;
    localparam int EV_COLD = 1;
    localparam int EV_BACKUP = 2;
    localparam int EV_VDROP = 3;
    localparam int EV_W = 4;
    localparam logic [3:0] INT_MASK_RST = 4'h0;
    localparam logic [7:0] RETAIN_RST = 8'h00;
    localparam logic [3:0] UNDEF_FILL = 4'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    // one machine cycle taken as one clock period
    localparam int MACHINE_CYCLE_NS = 100;
    localparam int RESET_HOLD_CYC = (MACHINE_CYCLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_RUN = 2'b00,
        ST_BACKUP = 2'b01,
        ST_RESTART = 2'b10
    } power_state_type;

    typedef enum logic [2:0]
    {
        OP_NONE = 3'b000,
        OP_ARM = 3'b001,
        OP_OFF = 3'b010,
        OP_SKIP_BACKUP = 3'b011,
        OP_SW_RESET = 3'b100,
        OP_OTHER = 3'b101
    } cpu_op_type;

    typedef struct packed
    {
        logic valid;
        cpu_op_type op;
    } cpu_instr_type;

    typedef struct packed
    {
        logic pin_reset_n;
        logic watchdog;
        logic vdrop;
        logic vdrop_enable;
        logic wakeup;
    } reset_sources_type;

    typedef struct packed
    {
        logic [3:0] ext_int_ctrl_a;
        logic [3:0] ext_int_ctrl_b;
    } retained_ctrl_type;

endpackage

// ==== src/input_sync.sv ====
// input_sync: two-flop synchroniser for a bundle of pin levels
// assumes: inputs asynchronous to sys_clk
`timescale 1ns/1ns
module input_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    // first stage feeds only the second
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            stage_one <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end
        else if (clk_en)
        begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end

endmodule

// ==== src/arm_tracker.sv ====
// arm_tracker: remembers whether the previous executed instruction armed power-off
// assumes: one instr.valid pulse per executed instruction
`timescale 1ns/1ns
module arm_tracker
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // instruction stream
    input wire backup_pkg::cpu_instr_type instr,
    input wire logic flush,
    // result
    output logic power_off_go,
    output logic armed
);

    assign power_off_go = instr.valid && instr.op == backup_pkg::OP_OFF && armed;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            armed <= 1'b0;
        end
        else if (clk_en)
        begin
            if (flush)
            begin
                armed <= 1'b0;
            end
            else if (instr.valid)
            begin
                armed <= (instr.op == backup_pkg::OP_ARM);
            end
        end
    end

endmodule

// ==== verif/backup_power_asserts.sv ====
// checker: timing relations seen at the power controller ports
// assumes: one clock domain, clk_en held high by the bench
`timescale 1ns/1ns
module backup_power_asserts
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // cpu core
    input wire backup_pkg::cpu_instr_type instr,
    input wire logic skip_next,
    input wire logic cpu_restart,
    input wire logic cpu_hold,
    input wire logic backup_flag,
    // sources
    input wire logic reset_n_pin,
    input wire logic watchdog_reset,
    input wire logic voltage_low,
    input wire logic voltage_detect_enable_pin,
    input wire logic wakeup_pin,
    // controls and bus
    input wire logic osc_stop,
    input wire logic onchip_osc_select,
    input wire logic ext_osc_run,
    input wire logic ram_write_block,
    input wire logic interrupt_enable_flag,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata
);
    // ------------------------------------------------------------
    // helpers and sequences
    // ------------------------------------------------------------
    // any executed instruction other than arm drops the arming
    logic arm_seen;
    always_ff @(posedge sys_clk)
    begin
        if (rst || cpu_restart)
            arm_seen <= 1'b0;
        else if (clk_en && instr.valid)
            arm_seen <= (instr.op == backup_pkg::OP_ARM);
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_arm_off;
        clk_en && instr.valid && instr.op == backup_pkg::OP_ARM && !osc_stop
        ##1 clk_en && instr.valid && instr.op == backup_pkg::OP_OFF;
    endsequence
    sequence s_vdet_masked;
        (voltage_low && !voltage_detect_enable_pin && reset_n_pin && !watchdog_reset
        && !wakeup_pin && !instr.valid)[*6];
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_ENTER: assert property (s_arm_off |=> osc_stop && ram_write_block && backup_flag)
        else $error("no back-up after arm then off");
    AST_OFF_NOP: assert property (clk_en && instr.valid && instr.op == backup_pkg::OP_OFF
        && !arm_seen && !osc_stop |=> !osc_stop)
        else $error("unarmed power-off entered back-up");
    AST_HOLD: assert property (osc_stop |-> ram_write_block && cpu_hold && backup_flag)
        else $error("back-up without hold or flag");
    AST_SKIP: assert property (clk_en && instr.valid && !osc_stop
        && instr.op == backup_pkg::OP_SKIP_BACKUP |-> skip_next == backup_flag)
        else $error("skip decision differs from flag");
    AST_WAKE: assert property (osc_stop && wakeup_pin |-> ##[1:5] (cpu_restart && backup_flag))
        else $error("wakeup gave no warm restart");
    AST_SWRST: assert property (clk_en && instr.valid && !osc_stop
        && instr.op == backup_pkg::OP_SW_RESET |-> ##[1:3] (cpu_restart && !backup_flag))
        else $error("software reset gave no cold restart");
    AST_WDOG: assert property ($rose(watchdog_reset) |-> ##[1:6] (cpu_restart && !backup_flag))
        else $error("watchdog gave no cold restart");
    AST_PIN: assert property ($fell(reset_n_pin) |-> ##[1:4] (cpu_hold && !backup_flag))
        else $error("reset pin did not force cold state");
    AST_VDROP: assert property ($rose(voltage_low && voltage_detect_enable_pin)
        |-> ##[1:6] !backup_flag)
        else $error("voltage drop did not reset");
    AST_VDET_OFF: assert property (s_vdet_masked |-> !cpu_restart)
        else $error("disabled detector caused a restart");
    AST_RST_STATE: assert property ($fell(rst)
        |-> onchip_osc_select && !ext_osc_run && !interrupt_enable_flag)
        else $error("wrong oscillator or interrupt state after reset");
    AST_RDATA: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
endmodule

bind ram_backup_power_control backup_power_asserts chk (.sys_clk(sys_clk), .rst(rst),
    .clk_en(clk_en), .instr(instr), .skip_next(skip_next), .cpu_restart(cpu_restart),
    .cpu_hold(cpu_hold), .backup_flag(backup_flag), .reset_n_pin(reset_n_pin),
    .watchdog_reset(watchdog_reset), .voltage_low(voltage_low),
    .voltage_detect_enable_pin(voltage_detect_enable_pin), .wakeup_pin(wakeup_pin),
    .osc_stop(osc_stop), .onchip_osc_select(onchip_osc_select), .ext_osc_run(ext_osc_run),
    .ram_write_block(ram_write_block), .interrupt_enable_flag(interrupt_enable_flag),
    .reg_read(reg_read), .reg_rdata(reg_rdata));

// ==== verif/cpu_core_model.sv ====
// cpu_core_model: core that executes one instruction per exec call
// assumes: callers enter exec and idle right after a rising edge
`timescale 1ns/1ns
module cpu_core_model
(
    // clock
    input wire logic sys_clk,
    // controller side
    input wire logic skip_next,
    output backup_pkg::cpu_instr_type instr,
    // bench side
    output logic last_skip
);
    initial
    begin
        instr = '0;
        last_skip = 1'b0;
    end
    task automatic exec(input backup_pkg::cpu_op_type op);
        instr <= '{valid: 1'b1, op: op};
        @(negedge sys_clk);
        last_skip = skip_next;
        @(posedge sys_clk);
    endtask
    // ends an instruction run without reusing the edge of the last one
    task automatic idle();
        instr <= '0;
        @(posedge sys_clk);
    endtask
endmodule

// ==== verif/ram_backup_power_control_tb_top.sv ====
// testbench: register and instruction sequences with expected values
// assumes: package, design, checker and core model compiled first
`timescale 1ns/1ns
module ram_backup_power_control_tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic reset_n_pin = 1'b1;
    logic watchdog_reset = 1'b0;
    logic voltage_low = 1'b0;
    logic voltage_detect_enable_pin = 1'b1;
    logic wakeup_pin = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    backup_pkg::cpu_instr_type instr;
    logic skip_next, cpu_restart, cpu_hold, backup_flag, osc_stop, onchip_osc_select;
    logic ext_osc_run, ram_write_block, carry_flag_clear, interrupt_enable_flag;
    logic volatile_clear, irq, last_skip;
    logic [7:0] reg_rdata;
    int num_errors = 0;
    int cmp_count = 0;

    always #50 sys_clk = ~sys_clk;

    ram_backup_power_control dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .instr(instr), .skip_next(skip_next), .cpu_restart(cpu_restart),
        .cpu_hold(cpu_hold), .backup_flag(backup_flag), .reset_n_pin(reset_n_pin),
        .watchdog_reset(watchdog_reset), .voltage_low(voltage_low),
        .voltage_detect_enable_pin(voltage_detect_enable_pin), .wakeup_pin(wakeup_pin),
        .osc_stop(osc_stop), .onchip_osc_select(onchip_osc_select),
        .ext_osc_run(ext_osc_run), .ram_write_block(ram_write_block),
        .carry_flag_clear(carry_flag_clear), .interrupt_enable_flag(interrupt_enable_flag),
        .volatile_clear(volatile_clear), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

    cpu_core_model cpu (.sys_clk(sys_clk), .skip_next(skip_next), .instr(instr),
        .last_skip(last_skip));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        @(negedge sys_clk);
        check(reg_rdata, exp);
        @(posedge sys_clk);
    endtask
    // restart pulse is caught at a falling edge, where outputs have settled
    task automatic wait_restart(input logic flag_exp);
        @(negedge sys_clk);
        for (int n = 0; n < 20 && cpu_restart !== 1'b1; n++)
            @(negedge sys_clk);
        // carry clear only on a cold start, volatile state dropped on both
        check({4'h0, carry_flag_clear, volatile_clear, cpu_restart, backup_flag},
            {4'h0, ~flag_exp, 2'b11, flag_exp});
        @(posedge sys_clk);
    endtask
    task automatic warm_cycle();
        cpu.exec(backup_pkg::OP_ARM);
        cpu.exec(backup_pkg::OP_OFF);
        cpu.idle();
        @(negedge sys_clk);
        check({4'h0, osc_stop, ram_write_block, cpu_hold, backup_flag}, 8'h0F);
        @(posedge sys_clk);
        wakeup_pin <= 1'b1;
        wait_restart(1'b1);
        wakeup_pin <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic tally_and_finish();
        if (num_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check({5'h00, onchip_osc_select, ext_osc_run, interrupt_enable_flag}, 8'h04);
        reg_rd(backup_pkg::OFS_CTRL, 8'h00);
        reg_rd(backup_pkg::OFS_INT_MASK, {4'h0, backup_pkg::INT_MASK_RST});
        reg_rd(backup_pkg::OFS_RETAIN, backup_pkg::RETAIN_RST);
        reg_rd(4'hF, 8'h00);
        reg_rd(backup_pkg::OFS_STATUS, 8'h04);
        cpu.exec(backup_pkg::OP_SKIP_BACKUP);
        cpu.idle();
        check({7'h00, last_skip}, 8'h00);
        cpu.exec(backup_pkg::OP_OFF);
        cpu.exec(backup_pkg::OP_ARM);
        cpu.exec(backup_pkg::OP_OTHER);
        cpu.exec(backup_pkg::OP_OFF);
        cpu.idle();
        @(negedge sys_clk);
        check({7'h00, osc_stop}, 8'h00);
        @(posedge sys_clk);
        reg_wr(backup_pkg::OFS_RETAIN, 8'hA5);
        reg_wr(backup_pkg::OFS_INT_STATUS, 8'h0F);
        reg_wr(backup_pkg::OFS_INT_MASK, 8'h01);
        warm_cycle();
        cpu.exec(backup_pkg::OP_SKIP_BACKUP);
        cpu.idle();
        check({7'h00, last_skip}, 8'h01);
        reg_rd(backup_pkg::OFS_RETAIN, 8'hA5);
        check({7'h00, irq}, 8'h01);
        reg_wr(backup_pkg::OFS_INT_STATUS, 8'h0F);
        reg_wr(backup_pkg::OFS_INT_MASK, 8'h00);
        check({7'h00, irq}, 8'h00);
        warm_cycle();
        check({7'h00, irq}, 8'h00);
        reg_rd(backup_pkg::OFS_INT_STATUS, 8'h05);
        watchdog_reset <= 1'b1;
        @(posedge sys_clk);
        watchdog_reset <= 1'b0;
        wait_restart(1'b0);
        warm_cycle();
        // restart pulse falls in the idle cycle, so it is watched in parallel
        fork
            begin
                cpu.exec(backup_pkg::OP_SW_RESET);
                cpu.idle();
            end
            wait_restart(1'b0);
        join
        warm_cycle();
        voltage_detect_enable_pin <= 1'b0;
        voltage_low <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check({7'h00, backup_flag}, 8'h01);
        voltage_detect_enable_pin <= 1'b1;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        check({7'h00, backup_flag}, 8'h00);
        @(posedge sys_clk);
        voltage_low <= 1'b0;
        repeat (8) @(posedge sys_clk);
        warm_cycle();
        reg_wr(backup_pkg::OFS_CTRL, 8'h02);
        wait_restart(1'b0);
        reg_wr(backup_pkg::OFS_CTRL, 8'h05);
        check({6'h00, ext_osc_run, interrupt_enable_flag}, 8'h03);
        // pin held low three machine cycles, above the minimum
        reset_n_pin <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n_pin <= 1'b1;
        wait_restart(1'b0);
        check({5'h00, onchip_osc_select, ext_osc_run, interrupt_enable_flag}, 8'h04);
        reg_rd(backup_pkg::OFS_RETAIN, 8'h00);
        tally_and_finish();
    end

    initial
    begin
        repeat (3000) @(posedge sys_clk);
        num_errors++;
        tally_and_finish();
    end
endmodule
